// ===== pmcg_pkg.sv
// Purpose: shared constants and types for the power mode and clock gating block
// Assumes: one 20 MHz clock, all wake and oscillator inputs asynchronous
// Notes: wake groups and state codes live here
package pmcg_pkg;
    localparam int unsigned PMCG_CLK_HZ = 20000000;
    localparam logic [2:0] PMCG_GEAR_RST = 3'h0;
    localparam int PMCG_SYNC_W = 4;
    localparam int PMCG_PCLK_MODS = 17;
    localparam int PMCG_LS_MODS = 11;

    typedef enum logic [1:0] {
        PMCG_RUN = 2'b00,
        PMCG_HALT = 2'b01,
        PMCG_SLEEP = 2'b10
    } pmcg_state_t;

    // wake requests grouped by method
    typedef struct packed {
        logic port_irq;
        logic debug_break;
        logic lowspeed_irq;
        logic pclk_irq;
    } pmcg_wake_t;

    // oscillator sleep-stop bits
    typedef struct packed {
        logic low_speed_osc_sleep_stop;
        logic internal_osc_sleep_stop;
        logic high_speed_osc_sleep_stop;
    } pmcg_slpctl_t;

    typedef struct packed {
        logic low_speed_oscillator;
        logic internal_oscillator;
        logic high_speed_oscillator;
    } pmcg_osc_t;
endpackage : pmcg_pkg

// ===== pmcg_gear.sv
// Purpose: gear divider producing cpu enable pulses
// Assumes: ratio is 0..7 for divide by 1..8
// Notes: ratio is only taken at a period boundary
`timescale 1ns/100ps
`default_nettype none
module pmcg_gear (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // control
    input wire logic run_i,
    input wire logic [2:0] ratio_i,
    // output
    output logic tick_o
);
    logic [2:0] count;
    logic [2:0] ratio;
    wire logic at_end = (count == ratio);

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            count <= 3'h0;
            ratio <= pmcg_pkg::PMCG_GEAR_RST;
        end else if (run_i) begin
            // new ratio only at wrap, so no short cpu period
            if (at_end) begin
                count <= 3'h0;
                ratio <= ratio_i;
            end else begin
                count <= count + 3'h1;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tick_o <= 1'b0;
        end else begin
            tick_o <= run_i && at_end;
        end
    end
endmodule : pmcg_gear
`default_nettype wire

// ===== pmcg_ctrl.sv
// Purpose: halt and sleep control, cpu gear, peripheral clock gating
// Assumes: clocks are represented as one-cycle enables of clk_i
// Notes: osc status inputs are asynchronous and synchronised here
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// [R1] halt stops cpu clock; peripherals keep state and may keep running
// [R2] halt ends on interrupt from port or running peripheral
// [R3] cpu clock is system clock divided by one to eight
// [R4] software bit stops the shared peripheral clock only
// [R5] peripheral-clock modules stop whenever that clock is gated
// [R6] low-speed functions run without the peripheral clock
// [R7] in sleep each oscillator runs if its stop bit is 0, else halts
// [R8] port interrupt or debug break wakes from halt and sleep
// [R9] low-speed peripheral interrupts wake the cpu from halt, not from sleep
// [R10] peripheral-clock interrupts wake the cpu while that clock runs
// [R11] sleep allows port wake; halt allows more depending on gating
// [R12] sleep with stop bits stops clocks; only port wake restarts
// [R13] gear and gate change only on clock boundaries, no short pulse
module pmcg_ctrl (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // cpu instructions, one-cycle pulses from the core
    input wire logic halt_req_i,
    input wire logic sleep_req_i,
    // configuration
    input wire logic [2:0] gear_ratio_i,
    input wire logic pclk_stop_i,
    input wire pmcg_pkg::pmcg_slpctl_t sleep_control_register_i,
    input wire pmcg_pkg::pmcg_osc_t osc_enable_i,
    // wake sources, asynchronous
    input wire pmcg_pkg::pmcg_wake_t wake_i,
    // clock enables and status
    output logic cpu_clk_en_o,
    output logic pclk_en_o,
    output logic lowspeed_en_o,
    output pmcg_pkg::pmcg_osc_t osc_run_o,
    output pmcg_pkg::pmcg_state_t state_o,
    output logic wake_o
);
    pmcg_pkg::pmcg_state_t state;
    pmcg_pkg::pmcg_state_t next_state;
    logic [pmcg_pkg::PMCG_SYNC_W-1:0] wake_s1;
    logic [pmcg_pkg::PMCG_SYNC_W-1:0] wake_s2;
    logic [2:0] osc_s1;
    logic [2:0] osc_s2;
    logic pclk_on;
    logic gear_tick;

    // two-stage synchronisers for wake and oscillator requests
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wake_s1 <= '0;
            wake_s2 <= '0;
            osc_s1 <= 3'h0;
            osc_s2 <= 3'h0;
        end else begin
            wake_s1 <= wake_i;
            wake_s2 <= wake_s1;
            osc_s1 <= osc_enable_i;
            osc_s2 <= osc_s1;
        end
    end

    wire logic port_wake = wake_s2[3] | wake_s2[2]; // [R8]
    wire logic ls_wake = wake_s2[1]; // [R9]
    wire logic pclk_wake = wake_s2[0] & pclk_on; // [R10]
    wire logic halt_wake = port_wake | ls_wake | pclk_wake; // [R2] [R11]
    wire logic sleep_wake = port_wake; // [R11] [R12]
    wire logic in_run = (state == pmcg_pkg::PMCG_RUN);
    wire logic in_sleep = (state == pmcg_pkg::PMCG_SLEEP);

    // sleep stops oscillators whose stop bit is set
    wire logic [2:0] stop_bits = sleep_control_register_i;
    wire logic [2:0] next_osc = in_sleep ? (osc_s2 & ~stop_bits) : osc_s2; // [R7]
    wire logic ls_running = next_osc[2];
    // peripheral clock runs in run and halt unless software stops it
    wire logic next_pclk_on = !pclk_stop_i && !in_sleep; // [R4] [R12]

    always_comb begin
        next_state = state;
        case (state)
            pmcg_pkg::PMCG_RUN: begin
                if (sleep_req_i) begin
                    next_state = pmcg_pkg::PMCG_SLEEP;
                end else if (halt_req_i) begin
                    next_state = pmcg_pkg::PMCG_HALT; // [R1]
                end
            end
            pmcg_pkg::PMCG_HALT: begin
                if (halt_wake) begin
                    next_state = pmcg_pkg::PMCG_RUN; // [R2]
                end
            end
            pmcg_pkg::PMCG_SLEEP: begin
                if (sleep_wake) begin
                    next_state = pmcg_pkg::PMCG_RUN; // [R8] [R12]
                end
            end
            default: begin
                next_state = pmcg_pkg::PMCG_RUN;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state <= pmcg_pkg::PMCG_RUN;
        end else begin
            state <= next_state;
        end
    end

    // cpu gear divider stops while halted or asleep
    pmcg_gear u_gear (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .run_i(in_run),
        .ratio_i(gear_ratio_i),
        .tick_o(gear_tick)
    ); // [R3] [R13]

    // gate changes only on system clock edges, so pulses are whole
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pclk_on <= 1'b1;
            cpu_clk_en_o <= 1'b0;
            pclk_en_o <= 1'b0;
            lowspeed_en_o <= 1'b0;
            osc_run_o <= '0;
            state_o <= pmcg_pkg::PMCG_RUN;
            wake_o <= 1'b0;
        end else begin
            pclk_on <= next_pclk_on; // [R13]
            cpu_clk_en_o <= gear_tick & in_run; // [R1]
            pclk_en_o <= next_pclk_on; // [R5]
            lowspeed_en_o <= ls_running; // [R6]
            osc_run_o <= next_osc; // [R7]
            state_o <= next_state;
            wake_o <= !in_run && (next_state == pmcg_pkg::PMCG_RUN);
        end
    end
endmodule : pmcg_ctrl
`default_nettype wire

// ===== pmcg_ctrl_checker.sv
// Purpose: port checks for the control block
// Assumes: one clock, reset active low
// Notes: windows allow for the wake synchroniser
`timescale 1ns/100ps
`default_nettype none
module pmcg_ctrl_checker (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // inputs
    input wire logic halt_req_i,
    input wire logic sleep_req_i,
    input wire logic [2:0] gear_ratio_i,
    input wire logic pclk_stop_i,
    input wire pmcg_pkg::pmcg_slpctl_t sleep_control_register_i,
    input wire pmcg_pkg::pmcg_wake_t wake_i,
    // outputs
    input wire logic cpu_clk_en_o,
    input wire logic pclk_en_o,
    input wire pmcg_pkg::pmcg_osc_t osc_run_o,
    input wire pmcg_pkg::pmcg_state_t state_o,
    input wire logic wake_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    wire run = state_o == pmcg_pkg::PMCG_RUN;
    wire slp = state_o == pmcg_pkg::PMCG_SLEEP;
    halt_go_a: assert property (run && halt_req_i && !sleep_req_i |=> !run && !slp)
        else $error("halt not taken");
    cpu_stop_a: assert property (!run && !$past(run) |-> !cpu_clk_en_o)
        else $error("cpu clock while stopped");
    gear_fast_a: assert property (cpu_clk_en_o && $past(cpu_clk_en_o) && gear_ratio_i == 3'h0
        && run && !halt_req_i && !sleep_req_i |=> cpu_clk_en_o)
        else $error("divide by one lost a tick");
    // the divider loads its ratio two cycles before the enable shows it
    gear_slow_a: assert property (cpu_clk_en_o && gear_ratio_i == 3'h7 && $stable(gear_ratio_i)
        && $past(gear_ratio_i, 2) == 3'h7 |=> !cpu_clk_en_o [*7])
        else $error("divide by eight too fast");
    pclk_gate_a: assert property ((pclk_stop_i || slp) [*4] |-> !pclk_en_o)
        else $error("peripheral clock not gated");
    wake_pulse_a: assert property (wake_o |-> (run && !$past(run)) ##1 !wake_o)
        else $error("wake pulse wrong");
    sleep_hold_a: assert property ((slp && !wake_i.port_irq && !wake_i.debug_break) [*4]
        |=> slp)
        else $error("left sleep without port wake");
    osc_stop_a: assert property ((slp && sleep_control_register_i.low_speed_osc_sleep_stop) [*2]
        |=> !osc_run_o.low_speed_oscillator)
        else $error("oscillator ran in sleep");
    cover property (!run && !slp ##1 wake_o);
    cover property (slp ##1 wake_o);
    cover property (pclk_stop_i && !run && !slp);
endmodule : pmcg_ctrl_checker
bind pmcg_ctrl pmcg_ctrl_checker chk (.*);
`default_nettype wire

// ===== tb_pmcg_ctrl.sv
// Purpose: bench for the control block
// Assumes: checker bound beside the design
// Notes: state changes matched against queued notes
`timescale 1ns/100ps
`default_nettype none
module tb_pmcg_ctrl;
    logic clk_i = 0, rst_n_i = 0, halt_req_i = 0, sleep_req_i = 0, pclk_stop_i = 0;
    logic [2:0] gear_ratio_i = 3'h0;
    pmcg_pkg::pmcg_slpctl_t sleep_control_register_i = 3'h5;
    pmcg_pkg::pmcg_osc_t osc_enable_i = 3'h7, osc_run_o;
    pmcg_pkg::pmcg_wake_t wake_i = 4'h0;
    pmcg_pkg::pmcg_state_t state_o, seen = pmcg_pkg::PMCG_RUN, q[$];
    logic cpu_clk_en_o, pclk_en_o, lowspeed_en_o, wake_o;
    int fails = 0, tests_run = 0, n;
    always #25 clk_i = ~clk_i;
    pmcg_ctrl uut (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .halt_req_i(halt_req_i),
        .sleep_req_i(sleep_req_i),
        .gear_ratio_i(gear_ratio_i),
        .pclk_stop_i(pclk_stop_i),
        .sleep_control_register_i(sleep_control_register_i),
        .osc_enable_i(osc_enable_i),
        .wake_i(wake_i),
        .cpu_clk_en_o(cpu_clk_en_o),
        .pclk_en_o(pclk_en_o),
        .lowspeed_en_o(lowspeed_en_o),
        .osc_run_o(osc_run_o),
        .state_o(state_o),
        .wake_o(wake_o)
    );
    task automatic chk(input string nm, input logic [3:0] e, a);
        tests_run++;
        if (e !== a) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", nm, e, a);
        end
    endtask : chk
    task automatic conclude();
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : conclude
    // bounded: a lost transition ends the run
    task automatic settle();
        for (n = 0; q.size() != 0; n++) begin
            if (n == 20) begin
                fails++;
                conclude();
            end
            @(negedge clk_i);
        end
    endtask : settle
    task automatic req(input logic s, input pmcg_pkg::pmcg_state_t e);
        halt_req_i = !s;
        sleep_req_i = s;
        q.push_back(e);
        @(negedge clk_i);
        halt_req_i = 0;
        sleep_req_i = 0;
        settle();
    endtask : req
    task automatic wake(input logic [3:0] w, input logic go);
        pmcg_pkg::pmcg_state_t was;
        was = state_o;
        wake_i = w;
        if (go) q.push_back(pmcg_pkg::PMCG_RUN);
        repeat (6) @(negedge clk_i);
        wake_i = 4'h0;
        if (!go) chk("held", was, state_o);
        // let the synchroniser drain so a stale wake cannot end the next halt
        repeat (3) @(negedge clk_i);
        settle();
    endtask : wake
    always @(negedge clk_i) begin
        if (rst_n_i && state_o !== seen) begin
            seen = state_o;
            chk("state", q.size() ? q.pop_front() : 4'hF, seen);
            chk("wake", 4'(seen == pmcg_pkg::PMCG_RUN), wake_o);
        end
    end
    initial begin
        void'($urandom(32'hAFEB));
        repeat (4) @(negedge clk_i);
        rst_n_i = 1;
        for (int r = 0; r < 8; r++) begin
            gear_ratio_i = 3'(r);
            repeat (9) @(negedge clk_i);
            n = 0;
            repeat (4 * r + 4) @(negedge clk_i) n += cpu_clk_en_o;
            chk("ticks", 4'h4, 4'(n));
        end
        for (int i = 0; i < 4; i++) begin
            gear_ratio_i = 3'($urandom);
            req(0, pmcg_pkg::PMCG_HALT);
            wake(4'h8 >> i, 1);
        end
        pclk_stop_i = 1;
        req(0, pmcg_pkg::PMCG_HALT);
        wake(4'h1, 0);
        chk("pclk", 4'h0, pclk_en_o);
        chk("lowspeed", 4'h1, lowspeed_en_o);
        wake(4'h2, 1);
        pclk_stop_i = 0;
        osc_enable_i = 3'($urandom);
        req(1, pmcg_pkg::PMCG_SLEEP);
        repeat (3) @(negedge clk_i);
        chk("osc", osc_enable_i & 3'h2, osc_run_o);
        wake(4'h3, 0);
        wake(4'h4, 1);
        repeat (2) @(negedge clk_i);
        chk("pclk", 4'h1, pclk_en_o);
        conclude();
    end
endmodule : tb_pmcg_ctrl
`default_nettype wire
